// File: acr_ch2_config.sv
// Purpose: Channel-2 configuration registers and their effect on the channel data path.
// Assumes: Byte register port; mod_tick marks one modulator clock cycle; samples are 16-bit signed.
// Notes: Gain is applied as 6.0 dB shifts, up to five 1 dB multiplies and a tenth-decibel fine table.
`include "acr_consts.svh"

module acr_ch2_config
  import acr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic mod_tick,
  input wire logic [15:0] ch1_filt_in,
  input wire logic [15:0] ch2_filt_in,
  input wire logic [15:0] ch3_filt_in,
  input wire logic sample_valid,
  output logic [7:0] reg_rdata,
  output logic [1:0] ch2_input_type,
  output logic [1:0] ch2_coupling_select,
  output logic ch2_range_select,
  output logic ch2_bandwidth_select,
  output logic [15:0] ch3_filt_sel,
  output logic [15:0] ch2_out,
  output logic ch2_out_valid
);
  acr_byte_t setup_ff, vol_ff, trim_ff, phase_ff, copy_ff;
  acr_byte_t nxt_setup, nxt_vol, nxt_trim, nxt_phase, nxt_copy;
  acr_byte_t rdata_ff, nxt_rdata;

  // Register writes; only implemented bits are stored so reserved ones read zero.
  always_comb begin
    nxt_setup = setup_ff;
    nxt_vol = vol_ff;
    nxt_trim = trim_ff;
    nxt_phase = phase_ff;
    nxt_copy = copy_ff;
    nxt_rdata = rdata_ff;
    if (reg_wr) begin
      unique case (reg_addr)
        `ACR_OFS_INPUT_SETUP: nxt_setup = reg_wdata & `ACR_MASK_INPUT_SETUP;
        `ACR_OFS_VOLUME: nxt_vol = reg_wdata & `ACR_MASK_VOLUME;
        `ACR_OFS_GAIN_TRIM: nxt_trim = reg_wdata & `ACR_MASK_GAIN_TRIM;
        `ACR_OFS_PHASE_TRIM: nxt_phase = reg_wdata & `ACR_MASK_PHASE_TRIM;
        `ACR_OFS_COPY_CTRL: nxt_copy = reg_wdata & `ACR_MASK_COPY_CTRL;
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `ACR_OFS_INPUT_SETUP: nxt_rdata = setup_ff;
        `ACR_OFS_VOLUME: nxt_rdata = vol_ff;
        `ACR_OFS_GAIN_TRIM: nxt_rdata = trim_ff;
        `ACR_OFS_PHASE_TRIM: nxt_rdata = phase_ff;
        `ACR_OFS_COPY_CTRL: nxt_rdata = copy_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      setup_ff <= `ACR_RST_INPUT_SETUP;
      vol_ff <= `ACR_RST_VOLUME;
      trim_ff <= `ACR_RST_GAIN_TRIM;
      phase_ff <= `ACR_RST_PHASE_TRIM;
      copy_ff <= `ACR_RST_COPY_CTRL;
      rdata_ff <= 8'h00;
    end else begin
      setup_ff <= nxt_setup;
      vol_ff <= nxt_vol;
      trim_ff <= nxt_trim;
      phase_ff <= nxt_phase;
      copy_ff <= nxt_copy;
      rdata_ff <= nxt_rdata;
    end
  end

  // Analog front-end controls; reserved codes pass through so the analog side can flag them.
  logic [1:0] in_type_ff, nxt_in_type, cpl_ff, nxt_cpl;
  logic range_ff, nxt_range, bw_ff, nxt_bw;
  logic [15:0] ch3_sel_ff, nxt_ch3_sel;

  always_comb begin
    nxt_in_type = setup_ff[7:6];
    nxt_cpl = setup_ff[3:2];
    nxt_range = setup_ff[1];
    nxt_bw = setup_ff[0];
    nxt_ch3_sel = copy_ff[7] ? ch1_filt_in : ch3_filt_in;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      in_type_ff <= 2'h0;
      cpl_ff <= 2'h0;
      range_ff <= 1'b0;
      bw_ff <= 1'b0;
      ch3_sel_ff <= 16'h0000;
    end else begin
      in_type_ff <= nxt_in_type;
      cpl_ff <= nxt_cpl;
      range_ff <= nxt_range;
      bw_ff <= nxt_bw;
      ch3_sel_ff <= nxt_ch3_sel;
    end
  end

  // Phase trim: a circular buffer written every modulator tick, read back code ticks later.
  logic [5:0] wptr_ff, nxt_wptr;
  logic [15:0] held_ff, nxt_held;
  logic [15:0] mem_rd;
  logic [5:0] rd_addr;
  logic [5:0] phase_code;

  assign phase_code = phase_ff[7:2];
  // The read is registered on the same tick that writes the newest sample, so the slot
  // code places behind the one being written holds the sample that is code ticks old, or 64 ticks old for code 0.
  assign rd_addr = 6'(wptr_ff - phase_code);

  acr_delay_mem u_delay (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(mod_tick),
    .wr_addr(wptr_ff),
    .wr_data(ch2_filt_in),
    .rd_addr(rd_addr),
    .rd_data(mem_rd)
  );

  always_comb begin
    nxt_wptr = wptr_ff;
    nxt_held = held_ff;
    if (mod_tick) begin
      nxt_wptr = 6'(wptr_ff + 6'h01);
      nxt_held = ch2_filt_in;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wptr_ff <= 6'h00;
      held_ff <= 16'h0000;
    end else begin
      wptr_ff <= nxt_wptr;
      held_ff <= nxt_held;
    end
  end

  logic [15:0] delayed;
  assign delayed = (phase_code == 6'h00) ? held_ff : mem_rd;

  // Gain: total step in tenths of a decibel, then a Q2.14 multiplier from tables.
  logic signed [11:0] tenth_db;
  logic signed [11:0] vol_tenths;
  logic signed [11:0] trim_tenths;
  logic [17:0] mult_q;

  // Total in 0.1 dB units: volume (code-161)*5 plus trim (code-8).
  always_comb begin
    vol_tenths = 12'(($signed({4'h0, vol_ff}) - 12'sd161) * 12'sd5);
    trim_tenths = 12'($signed({8'h00, trim_ff[7:4]}) - 12'sd8);
    tenth_db = 12'(vol_tenths + trim_tenths);
  end

  // 10^(x/200) in Q2.14 for x in 0..9 tenths, the remainder of a 1 dB octave-free split.
  function automatic logic [17:0] frac_gain(input logic [3:0] idx);
    logic [17:0] g;
    g = 18'h04000;
    unique case (idx)
      4'h0: g = 18'h04000;
      4'h1: g = 18'h040be;
      4'h2: g = 18'h0417e;
      4'h3: g = 18'h04240;
      4'h4: g = 18'h04304;
      4'h5: g = 18'h043cb;
      4'h6: g = 18'h04494;
      4'h7: g = 18'h0455f;
      4'h8: g = 18'h0462d;
      4'h9: g = 18'h046fd;
      default: g = 18'h04000;
    endcase
    return g;
  endfunction

  // Gain is split into 6.02 dB octaves approximated as 6.0 dB (shift), up to five 1 dB multiplies and a 0.1 dB fine table.
  logic signed [11:0] shift_amt;
  logic [5:0] rem_tenths;
  logic signed [11:0] base_oct;
  always_comb begin
    base_oct = 12'((tenth_db + 12'sd1200) / 12'sd60);
    shift_amt = 12'(base_oct - 12'sd20);
    rem_tenths = 6'((tenth_db + 12'sd1200) - base_oct * 12'sd60);
    mult_q = frac_gain(4'(rem_tenths % 6'd10));
    for (int i = 0; i < 5; i++) begin
      if (6'(i + 1) <= rem_tenths / 6'd10) begin
        mult_q = 18'((36'(mult_q) * 36'h0000047cf) >> 14);
      end
    end
  end

  logic signed [15:0] out_ff, nxt_out;
  logic vld_ff, nxt_vld;
  logic signed [35:0] prod;
  logic signed [35:0] scaled;

  always_comb begin
    prod = $signed(delayed) * $signed({1'b0, mult_q});
    scaled = prod >>> 14;
    if (shift_amt >= 0) begin
      scaled = scaled <<< shift_amt[3:0];
    end else begin
      scaled = scaled >>> (-shift_amt);
    end
    nxt_vld = sample_valid;
    nxt_out = out_ff;
    if (sample_valid) begin
      if (vol_ff == `ACR_VOL_MUTE) begin
        nxt_out = 16'sh0000;
      end else if (scaled > 36'sh00007fff) begin
        nxt_out = 16'sh7fff;
      end else if (scaled < -36'sh00008000) begin
        nxt_out = 16'sh8000;
      end else begin
        nxt_out = scaled[15:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      out_ff <= 16'sh0000;
      vld_ff <= 1'b0;
    end else begin
      out_ff <= nxt_out;
      vld_ff <= nxt_vld;
    end
  end

  assign reg_rdata = rdata_ff;
  assign ch2_input_type = in_type_ff;
  assign ch2_coupling_select = cpl_ff;
  assign ch2_range_select = range_ff;
  assign ch2_bandwidth_select = bw_ff;
  assign ch3_filt_sel = ch3_sel_ff;
  assign ch2_out = out_ff;
  assign ch2_out_valid = vld_ff;
endmodule // acr_ch2_config

// File: acr_ch2_config_bench.sv
// Purpose: Self-checking bench for the channel-2 config bank.
// Assumes: Read data is registered one cycle after the read strobe.
// Notes: Gain is checked at mute and for direction of change about unity only.
`include "acr_consts.svh"
module acr_ch2_config_bench
  import acr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, mod_tick = 1'b0, sample_valid = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [15:0] ch1_filt_in = 16'h0, ch2_filt_in = 16'h0, ch3_filt_in = 16'h0;
  logic [15:0] ch3_filt_sel, ch2_out;
  logic [1:0] ch2_input_type, ch2_coupling_select;
  logic ch2_range_select, ch2_bandwidth_select, ch2_out_valid;
  int err_count = 0, checks = 0, cyc = 0;
  logic [31:0] seed = 32'h34;
  logic [7:0] shadow [256];
  logic [15:0] hist [$];
  always #20 clk = ~clk;
  acr_ch2_config acr_ch2_config_i (.*);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      `ACR_OFS_INPUT_SETUP: return `ACR_MASK_INPUT_SETUP;
      `ACR_OFS_VOLUME: return `ACR_MASK_VOLUME;
      `ACR_OFS_GAIN_TRIM: return `ACR_MASK_GAIN_TRIM;
      `ACR_OFS_PHASE_TRIM: return `ACR_MASK_PHASE_TRIM;
      `ACR_OFS_COPY_CTRL: return `ACR_MASK_COPY_CTRL;
      default: return 8'h00;
    endcase
  endfunction
  task automatic wrap_up();
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (msk(a) != 8'h00) begin
      shadow[a] = d & msk(a);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk({8'h00, reg_rdata}, {8'h00, shadow[a]}, "read");
  endtask
  task automatic tick(input logic [15:0] d);
    @(posedge clk);
    mod_tick <= 1'b1;
    ch2_filt_in <= d;
    @(posedge clk);
    mod_tick <= 1'b0;
    hist.push_front(d);
  endtask
  task automatic smp(output logic [15:0] got);
    @(posedge clk);
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    #1 chk({15'h0, ch2_out_valid}, 16'h1, "strobe");
    got = ch2_out;
  endtask
  task automatic reset_dut();
    rst_b <= 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    foreach (shadow[i]) shadow[i] = 8'h00;
    shadow[`ACR_OFS_VOLUME] = `ACR_RST_VOLUME;
    shadow[`ACR_OFS_GAIN_TRIM] = `ACR_RST_GAIN_TRIM;
    for (int i = 8'h54; i < 8'h5c; i++) rd(i[7:0]);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      $display("wrong value at %0t: run hung", $time);
      wrap_up();
    end
  end
  initial begin
    logic [15:0] g;
    logic [7:0] a;
    static logic [7:0] va [4] = '{8'h81, 8'hc1, 8'ha1, 8'ha1};
    static logic [7:0] ta [4] = '{8'h80, 8'h80, 8'h00, 8'hf0};
    static int pc [4] = '{63, 5, 1, 0};
    reset_dut();
    repeat (60) begin
      a = 8'h54 + 8'(rnd() % 32'h7);
      wr(a, 8'(rnd()) & msk(a));
      rd(a);
    end
    reset_dut();
    for (int i = 0; i < 4; i++) begin
      wr(`ACR_OFS_INPUT_SETUP, {i[1:0], 2'h0, i[1:0], i[1], i[0]});
      repeat (2) @(posedge clk);
      #1 chk({10'h0, ch2_input_type, ch2_coupling_select, ch2_range_select,
        ch2_bandwidth_select}, {10'h0, i[1:0], i[1:0], i[1], i[0]}, "decode");
    end
    for (int i = 0; i < 2; i++) begin
      wr(`ACR_OFS_COPY_CTRL, {i[0], 7'h0});
      ch1_filt_in <= 16'(rnd());
      ch3_filt_in <= 16'(rnd());
      repeat (2) @(posedge clk);
      #1 chk(ch3_filt_sel, i[0] ? ch1_filt_in : ch3_filt_in, "copy");
    end
    foreach (pc[k]) begin
      wr(`ACR_OFS_PHASE_TRIM, {pc[k][5:0], 2'h0});
      repeat (64) tick(16'(rnd()));
      smp(g);
      chk(g, hist[pc[k]], "delay");
    end
    tick(16'h0400);
    foreach (va[k]) begin
      wr(`ACR_OFS_VOLUME, va[k]);
      wr(`ACR_OFS_GAIN_TRIM, ta[k]);
      smp(g);
      chk({15'h0, k[0] ? g > 16'h0400 : g < 16'h0400}, 16'h1, "gain");
    end
    wr(`ACR_OFS_VOLUME, `ACR_VOL_MUTE);
    smp(g);
    chk(g, 16'h0, "mute");
    wrap_up();
  end
endmodule // acr_ch2_config_bench

// File: acr_ch2_config_sva.sv
// Purpose: Port assertions for the channel-2 config bank.
// Assumes: One clock, synchronous active-low reset.
// Notes: A shadow volume byte judges muting.
`include "acr_consts.svh"
module acr_ch2_config_sva
  import acr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic mod_tick,
  input wire logic [15:0] ch1_filt_in,
  input wire logic [15:0] ch2_filt_in,
  input wire logic [15:0] ch3_filt_in,
  input wire logic sample_valid,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] ch2_input_type,
  input wire logic [1:0] ch2_coupling_select,
  input wire logic ch2_range_select,
  input wire logic ch2_bandwidth_select,
  input wire logic [15:0] ch3_filt_sel,
  input wire logic [15:0] ch2_out,
  input wire logic ch2_out_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [7:0] vol_ff;
  logic [7:0] nxt_vol;
  logic [7:0] msk;
  logic w55;
  logic w5a;
  assign w55 = reg_wr && reg_addr == `ACR_OFS_INPUT_SETUP;
  assign w5a = reg_wr && reg_addr == `ACR_OFS_COPY_CTRL;
  always_comb begin
    nxt_vol = vol_ff;
    if (!rst_b) begin
      nxt_vol = `ACR_RST_VOLUME;
    end else if (reg_wr && reg_addr == `ACR_OFS_VOLUME) begin
      nxt_vol = reg_wdata;
    end
    case (reg_addr)
      `ACR_OFS_INPUT_SETUP: msk = `ACR_MASK_INPUT_SETUP;
      `ACR_OFS_VOLUME: msk = `ACR_MASK_VOLUME;
      `ACR_OFS_GAIN_TRIM: msk = `ACR_MASK_GAIN_TRIM;
      `ACR_OFS_PHASE_TRIM: msk = `ACR_MASK_PHASE_TRIM;
      `ACR_OFS_COPY_CTRL: msk = `ACR_MASK_COPY_CTRL;
      default: msk = 8'h00;
    endcase
  end
  always_ff @(posedge clk) begin
    vol_ff <= nxt_vol;
  end
  property p_valid; sample_valid |=> ch2_out_valid; endproperty
  a_valid: assert property (p_valid) else $error("no output strobe");
  property p_quiet; !sample_valid |=> !ch2_out_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("stray output strobe");
  property p_mute; sample_valid && vol_ff == `ACR_VOL_MUTE |=> ch2_out == 16'h0; endproperty
  a_mute: assert property (p_mute) else $error("mute leaks");
  property p_type;
    w55 ##1 !w55 |=> ch2_input_type == $past(reg_wdata[7:6], 2)
      && ch2_coupling_select == $past(reg_wdata[3:2], 2);
  endproperty
  a_type: assert property (p_type) else $error("type or coupling wrong");
  property p_range;
    w55 ##1 !w55 |=> ch2_range_select == $past(reg_wdata[1], 2)
      && ch2_bandwidth_select == $past(reg_wdata[0], 2);
  endproperty
  a_range: assert property (p_range) else $error("range or bandwidth wrong");
  property p_copy;
    w5a ##1 !w5a |=> ch3_filt_sel ==
      ($past(reg_wdata[7], 2) ? $past(ch1_filt_in) : $past(ch3_filt_in));
  endproperty
  a_copy: assert property (p_copy) else $error("channel-3 source wrong");
  property p_resv; reg_rd |=> (reg_rdata & ~$past(msk)) == 8'h00; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits read set");
  property p_rst;
    disable iff (1'b0) !rst_b |=> ch2_out == 16'h0 && !ch2_out_valid && reg_rdata == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule // acr_ch2_config_sva

bind acr_ch2_config acr_ch2_config_sva acr_ch2_config_sva_i (.*);

// File: acr_consts.svh
// Purpose: Offsets, field positions, reset values and counts of the channel-2 config bank.
// Assumes: Byte-wide register port with an 8-bit address.
// Notes: Definitions only.
`ifndef ACR_CONSTS_SVH
`define ACR_CONSTS_SVH
`define ACR_OFS_INPUT_SETUP 8'h55
`define ACR_OFS_VOLUME 8'h57
`define ACR_OFS_GAIN_TRIM 8'h58
`define ACR_OFS_PHASE_TRIM 8'h59
`define ACR_OFS_COPY_CTRL 8'h5a
`define ACR_RST_INPUT_SETUP 8'h00
`define ACR_RST_VOLUME 8'ha1
`define ACR_RST_GAIN_TRIM 8'h80
`define ACR_RST_PHASE_TRIM 8'h00
`define ACR_RST_COPY_CTRL 8'h00
`define ACR_MASK_INPUT_SETUP 8'hcf
`define ACR_MASK_VOLUME 8'hff
`define ACR_MASK_GAIN_TRIM 8'hf0
`define ACR_MASK_PHASE_TRIM 8'hfc
`define ACR_MASK_COPY_CTRL 8'h80
`define ACR_VOL_MUTE 8'h00
`define ACR_VOL_UNITY 8'ha1
`define ACR_TRIM_UNITY 4'h8
`define ACR_GAIN_W 9
`define ACR_DELAY_DEPTH 64
`endif

// File: acr_delay_mem.sv
// Purpose: Sample delay line for the channel-2 phase trim.
// Assumes: One write and one read per modulator tick.
// Notes: Read data comes from a register.
module acr_delay_mem
  import acr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [5:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic [5:0] rd_addr,
  output logic [15:0] rd_data
);
  logic [15:0] mem_ff [0:63];
  logic [15:0] nxt_rd_data;
  logic [15:0] rd_data_ff;

  always_comb begin
    nxt_rd_data = rd_data_ff;
    if (wr_en) begin
      nxt_rd_data = mem_ff[rd_addr];
    end
  end

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_data_ff <= 16'h0000;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data = rd_data_ff;
endmodule // acr_delay_mem

// File: acr_pkg.sv
// Purpose: Types shared by the channel-2 config bank.
// Assumes: Nothing beyond the constants header.
// Notes: Step codes are in half-decibel units relative to unity.
package acr_pkg;
  typedef logic [7:0] acr_byte_t;
  typedef logic signed [8:0] acr_step_t;
  typedef enum logic [1:0] {
    ACR_IN_DIFF = 2'h0,
    ACR_IN_SE = 2'h1
  } acr_input_e;
  typedef enum logic [1:0] {
    ACR_CPL_AC = 2'h0,
    ACR_CPL_DC = 2'h1
  } acr_coupling_e;
endpackage
